// File: rtl/pcc_map.svh
`ifndef PCC_MAP_SVH
`define PCC_MAP_SVH

// Register byte offsets
`define PCC_CFG_OFF 12'h0D9
`define PCC_CMP_BASE_OFF 12'h100
`define PCC_RLD_BASE_OFF 12'h180
`define PCC_CNT_OFF 12'h200
`define PCC_WIDE_OFF 12'h204
`define PCC_IRQ_STAT_OFF 12'h208
`define PCC_IRQ_CLR_OFF 12'h20C
`define PCC_IRQ_EN_OFF 12'h210

// Configuration register fields
`define PCC_RELOAD_REGISTER_SELECT_BIT 7
`define PCC_CYCLE_OVERFLOW_IRQ_ENABLE_BIT 6
`define PCC_CYCLE_OVERFLOW_FLAG_BIT 5
`define PCC_CLSEL_HI 1
`define PCC_CLSEL_LO 0
`define PCC_CFG_RST 8'h00

// Other reset values
`define PCC_CNT_RST 16'h0000
`define PCC_CMP_RST 16'h0000
`define PCC_WIDE_RST 8'h00
`define PCC_IRQ_RST 1'b0

`endif

// File: rtl/pcc_pkg.sv
package pcc_pkg;

	typedef enum logic [1:0]
	{
		PCC_LEN_8,
		PCC_LEN_9,
		PCC_LEN_10,
		PCC_LEN_11
	} pcc_len_t;

	typedef enum logic [1:0]
	{
		PCC_IDLE,
		PCC_ACCESS
	} pcc_apb_t;

endpackage

// File: rtl/pcc_pwm_cycle.sv
// Functional notes
// - Select bit clear routes compare-slot accesses to the capture/compare values.
// - Select bit set routes compare-slot accesses to the auto-reload values.
// - Reload values act only in 9, 10 and 11-bit cycle lengths.
// - Overflow interrupt enable gates the overflow flag onto the interrupt.
// - Flag sets when counter carries out of the bit chosen by length.
// - Flag set by hardware or software write of 1; only software clears.
// - Bits 4 to 2 read zero and ignore writes.
// - Length codes 00, 01, 10 give 8, 9, 10 bits.
// - Channels in 16-bit mode ignore the cycle length select.
// - Per-channel wide select picks shared short cycle or 16-bit cycle.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "pcc_map.svh"

module pcc_pwm_cycle #(
	parameter int NCH = 6
) (
	input wire logic clk_in, // System clock
	input wire logic sys_rst_in, // Async reset, active high
	input wire logic clk_en_in, // Freezes all state when low
	input wire logic cnt_tick_in, // Counter advance strobe
	input wire logic psel_in, // APB select
	input wire logic penable_in, // APB enable
	input wire logic pwrite_in, // APB direction
	input wire logic [11:0] paddr_in, // APB byte address
	input wire logic [31:0] pwdata_in, // APB write data
	output logic [31:0] prdata_out, // APB read data
	output logic pready_out, // APB ready
	output logic pslverr_out, // APB error
	output logic [NCH-1:0] pwm_out, // PWM channel outputs
	output logic [NCH-1:0] cyc_end_out, // Cycle end strobe per channel
	output logic irq_out // Interrupt request
);

	// ****************************************
	// Functions
	// ****************************************
	function automatic logic [3:0] len_bits(input pcc_pkg::pcc_len_t l);
		unique case (l)
			pcc_pkg::PCC_LEN_8: len_bits = 4'h8;
			pcc_pkg::PCC_LEN_9: len_bits = 4'h9;
			pcc_pkg::PCC_LEN_10: len_bits = 4'hA;
			pcc_pkg::PCC_LEN_11: len_bits = 4'hB;
		endcase
	endfunction

	function automatic logic [15:0] len_mask(input pcc_pkg::pcc_len_t l);
		len_mask = 16'(16'hFFFF >> (16 - len_bits(l)));
	endfunction

	// ****************************************
	// State
	// ****************************************
	logic reload_register_select;
	logic cycle_overflow_irq_enable;
	logic cycle_overflow_flag;
	pcc_pkg::pcc_len_t cycle_length_select;
	logic [15:0] main_counter;
	logic [15:0] cmp_val [NCH];
	logic [15:0] rld_val [NCH];
	logic [NCH-1:0] wide_pwm_select;
	logic irq_en;
	pcc_pkg::pcc_apb_t apb_st;
	logic [15:0] next_counter;
	logic [15:0] cmask;
	logic ovf_evt;
	logic [7:0] cfg_rd;
	logic rld_wr_seen;

	wire logic acc = psel_in & penable_in & (apb_st == pcc_pkg::PCC_ACCESS);
	wire logic wr = acc & pwrite_in;
	wire logic cfg_wr = wr & (paddr_in == `PCC_CFG_OFF);
	wire logic clr_wr = wr & (paddr_in == `PCC_IRQ_CLR_OFF);

	assign cmask = len_mask(cycle_length_select);
	assign next_counter = 16'(main_counter + 16'h0001);
	// Carry out of the selected bit of the counter
	assign ovf_evt = cnt_tick_in & ((main_counter & cmask) == cmask);
	assign cfg_rd = {reload_register_select, cycle_overflow_irq_enable,
		cycle_overflow_flag, 3'h0, cycle_length_select};
	assign rld_wr_seen = wr & reload_register_select;

	// ****************************************
	// APB handshake: one wait state
	// ****************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			apb_st <= pcc_pkg::PCC_IDLE;
		else if (clk_en_in)
		begin
			unique case (apb_st)
				pcc_pkg::PCC_IDLE:
					if (psel_in & penable_in)
						apb_st <= pcc_pkg::PCC_ACCESS;
				pcc_pkg::PCC_ACCESS:
					apb_st <= pcc_pkg::PCC_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
		end
		else if (clk_en_in)
		begin
			pready_out <= psel_in & penable_in & (apb_st == pcc_pkg::PCC_IDLE);
			pslverr_out <= 1'b0;
			prdata_out <= 32'h0000_0000;
			if (psel_in & penable_in & (apb_st == pcc_pkg::PCC_IDLE)
				& !pwrite_in)
			begin
				if (paddr_in == `PCC_CFG_OFF)
					prdata_out <= {24'h0, cfg_rd};
				else if (paddr_in == `PCC_CNT_OFF)
					prdata_out <= {16'h0, main_counter};
				else if (paddr_in == `PCC_WIDE_OFF)
					prdata_out <= 32'(wide_pwm_select);
				else if (paddr_in == `PCC_IRQ_STAT_OFF)
					prdata_out <= {31'h0, cycle_overflow_flag};
				else if (paddr_in == `PCC_IRQ_EN_OFF)
					prdata_out <= {31'h0, irq_en};
				for (int i = 0; i < NCH; i++)
				begin
					if (paddr_in == 12'(`PCC_CMP_BASE_OFF + 4 * i))
						prdata_out <= reload_register_select ?
							{16'h0, rld_val[i]} :
							{16'h0, cmp_val[i]};
				end
			end
			if (psel_in & penable_in & (apb_st == pcc_pkg::PCC_IDLE)
				& !pwrite_in & !(paddr_in inside {`PCC_CFG_OFF,
				`PCC_CNT_OFF, `PCC_WIDE_OFF, `PCC_IRQ_STAT_OFF,
				`PCC_IRQ_EN_OFF, `PCC_IRQ_CLR_OFF})
				& !((paddr_in >= `PCC_CMP_BASE_OFF)
				& (paddr_in < 12'(`PCC_CMP_BASE_OFF + 4 * NCH))
				& (paddr_in[1:0] == 2'h0)))
				pslverr_out <= 1'b1;
		end
	end

	// ****************************************
	// Configuration register
	// ****************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			reload_register_select <= 1'b0;
			cycle_overflow_irq_enable <= 1'b0;
			cycle_length_select <= pcc_pkg::PCC_LEN_8;
		end
		else if (clk_en_in & cfg_wr)
		begin
			reload_register_select <= pwdata_in[`PCC_RELOAD_REGISTER_SELECT_BIT];
			cycle_overflow_irq_enable <= pwdata_in[`PCC_CYCLE_OVERFLOW_IRQ_ENABLE_BIT];
			cycle_length_select <= pcc_pkg::pcc_len_t'(
				pwdata_in[`PCC_CLSEL_HI:`PCC_CLSEL_LO]);
		end
	end

	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			cycle_overflow_flag <= 1'b0;
		else if (clk_en_in)
		begin
			if (ovf_evt)
				cycle_overflow_flag <= 1'b1;
			else if (cfg_wr)
				cycle_overflow_flag <= pwdata_in[`PCC_CYCLE_OVERFLOW_FLAG_BIT];
			else if (clr_wr & pwdata_in[0])
				cycle_overflow_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
		begin
			irq_en <= `PCC_IRQ_RST;
			wide_pwm_select <= NCH'(`PCC_WIDE_RST);
		end
		else if (clk_en_in & wr)
		begin
			if (paddr_in == `PCC_IRQ_EN_OFF)
				irq_en <= pwdata_in[0];
			if (paddr_in == `PCC_WIDE_OFF)
				wide_pwm_select <= pwdata_in[NCH-1:0];
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			irq_out <= 1'b0;
		else if (clk_en_in)
			irq_out <= (cycle_overflow_flag | ovf_evt)
				& cycle_overflow_irq_enable & irq_en;
	end

	// ****************************************
	// Main counter
	// ****************************************
	always_ff @(posedge clk_in or posedge sys_rst_in)
	begin
		if (sys_rst_in)
			main_counter <= `PCC_CNT_RST;
		else if (clk_en_in)
		begin
			if (wr & (paddr_in == `PCC_CNT_OFF))
				main_counter <= pwdata_in[15:0];
			else if (cnt_tick_in)
				main_counter <= next_counter;
		end
	end

	// ****************************************
	// Channels
	// ****************************************
	generate
		for (genvar g = 0; g < NCH; g++)
		begin : gen_ch
			wire logic slot_wr = wr
				& (paddr_in == 12'(`PCC_CMP_BASE_OFF + 4 * g));
			wire logic wrap = wide_pwm_select[g] ?
				(cnt_tick_in & (main_counter == 16'hFFFF)) :
				ovf_evt;
			always_ff @(posedge clk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
				begin
					cmp_val[g] <= `PCC_CMP_RST;
					rld_val[g] <= `PCC_CMP_RST;
				end
				else if (clk_en_in)
				begin
					if (slot_wr & reload_register_select)
						rld_val[g] <= pwdata_in[15:0];
					else if (slot_wr)
						cmp_val[g] <= pwdata_in[15:0];
					else if (wrap & !wide_pwm_select[g]
						& (cycle_length_select != pcc_pkg::PCC_LEN_8))
						cmp_val[g] <= rld_val[g];
				end
			end
			always_ff @(posedge clk_in or posedge sys_rst_in)
			begin
				if (sys_rst_in)
				begin
					pwm_out[g] <= 1'b0;
					cyc_end_out[g] <= 1'b0;
				end
				else if (clk_en_in)
				begin
					cyc_end_out[g] <= wrap;
					if (wide_pwm_select[g])
						pwm_out[g] <= main_counter < cmp_val[g];
					else
						pwm_out[g] <= (main_counter & cmask)
							< (cmp_val[g] & cmask);
				end
			end
		end
	endgenerate

	// ****************************************
	// Assertions
	// ****************************************
	ovf_sets_flag_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & ovf_evt |=> cycle_overflow_flag)
		else $error("overflow did not set flag");
	flag_sticky_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		cycle_overflow_flag & !cfg_wr & !clr_wr |=> cycle_overflow_flag)
		else $error("flag cleared without software");
	irq_gate_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & !cycle_overflow_irq_enable |=> !irq_out)
		else $error("interrupt while masked");
	irq_raise_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & cycle_overflow_flag & cycle_overflow_irq_enable & irq_en
		|=> irq_out)
		else $error("interrupt missing");
	unused_zero_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & psel_in & penable_in & (apb_st == pcc_pkg::PCC_IDLE)
		& !pwrite_in & (paddr_in == `PCC_CFG_OFF) |=> prdata_out[4:2] == 3'h0)
		else $error("unused bits not zero");
	len_map_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		cmask == 16'(16'hFFFF >> (16 - 4'h8 - cycle_length_select)))
		else $error("cycle length mask wrong");
	len11_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		cycle_length_select == pcc_pkg::PCC_LEN_11 |-> cmask == 16'h07FF)
		else $error("11-bit mask wrong");
	sel_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & wr & (paddr_in == `PCC_CMP_BASE_OFF)
		& !reload_register_select |=> cmp_val[0] == $past(pwdata_in[15:0]))
		else $error("compare write lost");
	rld_route_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & wr & (paddr_in == `PCC_CMP_BASE_OFF)
		& reload_register_select |=> rld_val[0] == $past(pwdata_in[15:0]))
		else $error("reload write lost");
	rld_8bit_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & (cycle_length_select == pcc_pkg::PCC_LEN_8) & !wr
		|=> $stable(cmp_val[0]))
		else $error("reload acted in 8-bit mode");
	wide_wrap_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & wide_pwm_select[0] & ovf_evt & (main_counter != 16'hFFFF)
		|=> !cyc_end_out[0])
		else $error("wide channel followed short cycle");
	rdy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & pready_out |=> !pready_out)
		else $error("ready held");
	wide_end_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & wide_pwm_select[0] & cnt_tick_in
		& (main_counter == 16'hFFFF) |=> cyc_end_out[0])
		else $error("wide channel missed 16-bit wrap");
	rld_copy_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		clk_en_in & ovf_evt & !wr & !wide_pwm_select[0]
		& (cycle_length_select != pcc_pkg::PCC_LEN_8)
		|=> cmp_val[0] == $past(rld_val[0]))
		else $error("reload not applied at wrap");
	freeze_cnt_a: assert property (@(posedge clk_in) disable iff (sys_rst_in)
		!clk_en_in |=> $stable(main_counter))
		else $error("counter moved while frozen");

	// Main scenarios
	ovf_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		ovf_evt);
	irq_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		irq_out);
	rld_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		rld_wr_seen);
	wide_c: cover property (@(posedge clk_in) disable iff (sys_rst_in)
		wide_pwm_select[0] & cyc_end_out[0]);

endmodule
`default_nettype wire

// File: tb/test_pwm_cycle_configuration.sv
`timescale 1ns/10ps
`default_nettype none
`include "pcc_map.svh"

module test_pwm_cycle_configuration;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b1;
	logic cnt_tick_in = 1'b0;
	logic psel_in = 1'b0;
	logic penable_in = 1'b0;
	logic pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h0000_0000;
	logic [31:0] prdata_out;
	logic pready_out;
	logic pslverr_out;
	logic [5:0] pwm_out;
	logic irq_out;
	logic clk_en_in = 1'b1;
	logic [5:0] cyc_end_out;
	int end0 = 0;
	int end1 = 0;
	logic [31:0] rd;
	logic er;
	int error_cnt = 0;
	int compares = 0;

	always #20 clk_in = ~clk_in;

	// Counts cycle-end pulses of the first two channels
	always @(posedge clk_in)
	begin
		if (cyc_end_out[0])
			end0 <= end0 + 1;
		if (cyc_end_out[1])
			end1 <= end1 + 1;
	end

	pcc_pwm_cycle #(.NCH(6)) u_dut (
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.clk_en_in(clk_en_in),
		.cnt_tick_in(cnt_tick_in),
		.psel_in(psel_in),
		.penable_in(penable_in),
		.pwrite_in(pwrite_in),
		.paddr_in(paddr_in),
		.pwdata_in(pwdata_in),
		.prdata_out(prdata_out),
		.pready_out(pready_out),
		.pslverr_out(pslverr_out),
		.pwm_out(pwm_out),
		.cyc_end_out(cyc_end_out),
		.irq_out(irq_out)
	);

	// ****************************************
	// Shared tasks
	// ****************************************
	task automatic test_done();
		$display("compares %0d error_cnt %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		compares++;
		if (got !== exp)
		begin
			$display("unexpected %s expected %h seen %h", nm, exp, got);
			error_cnt++;
		end
	endtask

	// Called right after a rising edge; returns one edge after release
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		n = 0;
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 40);
		if (pready_out !== 1'b1)
		begin
			$display("unexpected pready expected 1 seen %b", pready_out);
			error_cnt++;
			test_done();
		end
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), exp, rd);
	endtask

	task automatic irqc(input logic exp);
		repeat (2) @(posedge clk_in);
		chk("irq_out", {31'h0000_0000, exp}, {31'h0000_0000, irq_out});
	endtask

	task automatic tick(input int n);
		cnt_tick_in <= 1'b1;
		repeat (n) @(posedge clk_in);
		cnt_tick_in <= 1'b0;
		@(posedge clk_in);
	endtask

	task automatic rst();
		sys_rst_in <= 1'b1;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		@(posedge clk_in);
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_regs();
		rst();
		rdc(`PCC_CFG_OFF, 32'h0000_0000);
		apb(1'b0, 12'h3F0, 32'h0000_0000);
		chk("pslverr", 32'h0000_0001, {31'h0000_0000, er});
		apb(1'b1, `PCC_CFG_OFF, 32'h0000_00FF);
		rdc(`PCC_CFG_OFF, 32'h0000_00E3);
		apb(1'b1, `PCC_IRQ_EN_OFF, 32'h0000_0001);
		irqc(1'b1);
		apb(1'b1, `PCC_CFG_OFF, 32'h0000_00A3);
		irqc(1'b0);
		repeat (20) @(posedge clk_in);
		rdc(`PCC_IRQ_STAT_OFF, 32'h0000_0001);
		apb(1'b1, `PCC_CFG_OFF, 32'h0000_0043);
		rdc(`PCC_CFG_OFF, 32'h0000_0043);
		irqc(1'b0);
		apb(1'b1, `PCC_CFG_OFF, 32'h0000_0063);
		irqc(1'b1);
		apb(1'b1, `PCC_IRQ_CLR_OFF, 32'h0000_0001);
		rdc(`PCC_IRQ_STAT_OFF, 32'h0000_0000);
		irqc(1'b0);
	endtask

	task automatic t_ovf();
		for (int c = 0; c < 4; c++)
		begin
			rst();
			apb(1'b1, `PCC_IRQ_EN_OFF, 32'h0000_0001);
			apb(1'b1, `PCC_CFG_OFF, 32'h0000_0040 | c);
			tick((256 << c) - 1);
			rdc(`PCC_IRQ_STAT_OFF, 32'h0000_0000);
			irqc(1'b0);
			tick(1);
			rdc(`PCC_CFG_OFF, 32'h0000_0060 | c);
			irqc(1'b1);
		end
	endtask

	task automatic t_slots();
		for (int c = 0; c < 4; c++)
		begin
			rst();
			apb(1'b1, `PCC_CFG_OFF, c);
			apb(1'b1, `PCC_CMP_BASE_OFF, 32'h0000_0010);
			apb(1'b1, `PCC_CFG_OFF, 32'h0000_0080 | c);
			apb(1'b1, `PCC_CMP_BASE_OFF, 32'h0000_0040);
			rdc(`PCC_CMP_BASE_OFF, 32'h0000_0040);
			apb(1'b1, `PCC_CFG_OFF, c);
			rdc(`PCC_CMP_BASE_OFF, 32'h0000_0010);
			tick((256 << c) + 32);
			repeat (3) @(posedge clk_in);
			chk("pwm_out0", {31'h0000_0000, c != 0},
				{31'h0000_0000, pwm_out[0]});
		end
	endtask

	task automatic t_wide();
		int b0;
		int b1;
		rst();
		apb(1'b1, `PCC_WIDE_OFF, 32'h0000_0001);
		rdc(`PCC_WIDE_OFF, 32'h0000_0001);
		apb(1'b1, `PCC_CMP_BASE_OFF, 32'h0000_0020);
		apb(1'b1, 12'(`PCC_CMP_BASE_OFF + 4), 32'h0000_0020);
		b0 = end0;
		b1 = end1;
		tick(272);
		repeat (2) @(posedge clk_in);
		chk("pwm_out0", 32'h0000_0000, {31'h0000_0000, pwm_out[0]});
		chk("pwm_out1", 32'h0000_0001, {31'h0000_0000, pwm_out[1]});
		chk("cyc_end0 count", 32'h0000_0000, end0 - b0);
		chk("cyc_end1 count", 32'h0000_0001, end1 - b1);
		apb(1'b1, `PCC_CNT_OFF, 32'h0000_FFF0);
		rdc(`PCC_CNT_OFF, 32'h0000_FFF0);
		b0 = end0;
		b1 = end1;
		tick(32);
		repeat (2) @(posedge clk_in);
		chk("cyc_end0 count", 32'h0000_0001, end0 - b0);
		chk("cyc_end1 count", 32'h0000_0001, end1 - b1);
		clk_en_in <= 1'b0;
		tick(5);
		clk_en_in <= 1'b1;
		rdc(`PCC_CNT_OFF, 32'h0000_0010);
	endtask

	initial
	begin
		t_regs();
		t_ovf();
		t_slots();
		t_wide();
		test_done();
	end
endmodule

`default_nettype wire
